// file: timer_pkg.sv
// package: constants shared by the quad timer and its prescaler
package timer_pkg;
    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int          CNT_W         = 32;
    localparam int          PRE_W         = 16;
    localparam logic [31:0] CNT_RST       = 32'h0000_0000;
    localparam logic [31:0] WDOG_RST      = 32'hFFFF_FFFF;
    localparam logic [15:0] PRE_RST       = 16'h0001;
    // ------------------------------------------------------------
    // clock rates: bus clock 66.667 MHz, derived prescaler clock 50 MHz
    // ------------------------------------------------------------
    localparam int          BUS_CLK_KHZ   = 66667;
    localparam int          ALT_PERIOD_NS = 20;
    // prescaler input choice
    typedef enum logic [0:0] {
        PRE_SRC_BUS = 1'b0,
        PRE_SRC_ALT = 1'b1
    } pre_src_t;
endpackage : timer_pkg

// file: timer_prescaler.sv
// prescaler: programmable divider producing a one-cycle count enable
`timescale 1ns/1ps
module timer_prescaler #(
    parameter int PRE_W = timer_pkg::PRE_W
) (
    // clock and reset
    input  wire logic             clock_i,
    input  wire logic             arst_n_i,
    // configuration
    input  wire logic [PRE_W-1:0] divide_m1_i,
    input  wire logic             src_alt_i,
    input  wire logic             alt_tick_i,
    // output
    output logic                  enable_o
);
    logic [PRE_W-1:0] count_r;
    logic             src_tick;

    // the derived 50 MHz source arrives as a tick, never as a clock
    assign src_tick = (src_alt_i == timer_pkg::PRE_SRC_ALT) ? alt_tick_i : 1'b1; // [RL5]

    // ratio is divide_m1_i + 1, so 1..FFFF gives 2..65536
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            count_r  <= '0;
            enable_o <= 1'b0;
        end else begin
            enable_o <= 1'b0;
            if (src_tick) begin
                if (count_r >= divide_m1_i) begin // [RL4]
                    count_r  <= '0;
                    enable_o <= 1'b1; // [RL7]
                end else begin
                    count_r <= count_r + 1'b1;
                end
            end
        end
    end
endmodule : timer_prescaler

// file: quad_timer_with_prescaler.sv
// quad timer: watchdog, timestamp with compare, two reloading timers
`timescale 1ns/1ps
// Summary of operation
// RL1: four independent 32-bit counters: watchdog, timestamp, two general purpose.
// RL2: all counters are clocked from the single timer clock.
// RL3: timestamp and both general timers may count on prescaler enable; watchdog not.
// RL4: prescaler divides by programmed 16-bit value plus one, ratio 2 to 65536 for values 1 to FFFF.
// RL5: prescaler input is bus clock or the derived 50 MHz tick.
// RL6: after reset every timer counts every clock, prescaling off.
// RL7: prescaler output is a one-cycle enable pulse, never a clock.
// RL8: timestamp raises interrupt when count equals 32-bit compare value.
// RL9: watchdog decrements while enabled; reaching zero unreloaded asserts expiry.
// RL10: general timers flag terminal count, reload, keep counting; software clears.
module quad_timer_with_prescaler #(
    parameter int CNT_W = timer_pkg::CNT_W,
    parameter int PRE_W = timer_pkg::PRE_W
) (
    // clock and reset
    input  wire logic             clock_i,
    input  wire logic             arst_n_i,
    // prescaler control
    input  wire logic [PRE_W-1:0] pre_divide_m1_i,
    input  wire logic             pre_src_alt_i,
    input  wire logic             alt_tick_i,
    input  wire logic             ts_use_pre_i,
    input  wire logic             gp0_use_pre_i,
    input  wire logic             gp1_use_pre_i,
    // watchdog control
    input  wire logic             wdog_enable_i,
    input  wire logic             wdog_reload_i,
    input  wire logic [CNT_W-1:0] wdog_value_i,
    // timestamp control
    input  wire logic             ts_enable_i,
    input  wire logic             ts_load_i,
    input  wire logic [CNT_W-1:0] ts_value_i,
    input  wire logic             cmp_write_i,
    input  wire logic [CNT_W-1:0] cmp_value_i,
    input  wire logic             ts_irq_clear_i,
    // general-purpose control
    input  wire logic [1:0]       gp_enable_i,
    input  wire logic [1:0]       gp_load_i,
    input  wire logic [CNT_W-1:0] gp0_reload_i,
    input  wire logic [CNT_W-1:0] gp1_reload_i,
    input  wire logic [1:0]       gp_irq_clear_i,
    // status
    output logic [CNT_W-1:0]      wdog_count_o,
    output logic                  wdog_expired_o,
    output logic [CNT_W-1:0]      ts_count_o,
    output logic [CNT_W-1:0]      cmp_o,
    output logic                  ts_irq_o,
    output logic [CNT_W-1:0]      gp0_count_o,
    output logic [CNT_W-1:0]      gp1_count_o,
    output logic [1:0]            gp_irq_o,
    output logic                  pre_enable_o
);
    // ------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------
    logic pre_en;

    timer_prescaler #(
        .PRE_W      (PRE_W)
    ) u_pre (
        .clock_i     (clock_i),
        .arst_n_i    (arst_n_i),
        .divide_m1_i (pre_divide_m1_i),
        .src_alt_i   (pre_src_alt_i),
        .alt_tick_i  (alt_tick_i),
        .enable_o    (pre_en)
    );

    // ------------------------------------------------------------
    // observation copy of the enable
    // ------------------------------------------------------------
    // registered so the port comes from a flop; it trails pre_en
    // by one cycle, so anything watching it must allow for that lag
    // rather than treat it as the enable that moved the count
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pre_enable_o <= 1'b0;
        end else begin
            pre_enable_o <= pre_en;
        end
    end

    // ------------------------------------------------------------
    // per-counter step enables
    // ------------------------------------------------------------
    // selects are inputs that software holds low after reset, so every
    // counter starts on the plain timer clock; pre_en is high for one
    // clock per division period and is never used as a clock
    function automatic logic step_en(input logic use_pre, input logic pre);
        step_en = use_pre ? pre : 1'b1; // [RL3] [RL6]
    endfunction : step_en

    logic ts_step;
    logic gp0_step;
    logic gp1_step;
    assign ts_step  = step_en(ts_use_pre_i, pre_en);
    assign gp0_step = step_en(gp0_use_pre_i, pre_en);
    assign gp1_step = step_en(gp1_use_pre_i, pre_en);

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    // every counter below shares clock_i, the one timer clock [RL2]
    // the watchdog never looks at the prescaler, so a bad divide setting
    // cannot stretch the time to expiry [RL3]
    logic wdog_at_zero;
    assign wdog_at_zero = (wdog_count_o == '0);

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wdog_count_o   <= timer_pkg::WDOG_RST;
            wdog_expired_o <= 1'b0;
        end else if (wdog_reload_i) begin
            wdog_count_o   <= wdog_value_i; // [RL9]
            wdog_expired_o <= 1'b0;
        end else if (wdog_enable_i) begin
            // sticky: only a reload or reset drops the reset request
            if (wdog_at_zero) begin
                wdog_expired_o <= 1'b1; // [RL9]
            end else begin
                wdog_count_o <= wdog_count_o - 1'b1; // [RL9] [RL1]
            end
        end
    end

    // ------------------------------------------------------------
    // timestamp counter
    // ------------------------------------------------------------
    logic ts_advance;
    logic ts_match;
    assign ts_advance = ts_enable_i && ts_step; // [RL3]
    // the match is taken on the count before the step, so the flag and
    // the count that follows it land on the same edge
    assign ts_match   = ts_advance && (ts_count_o == cmp_o); // [RL8]

    // a load wins over a step, so software can set the count without
    // racing the increment
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ts_count_o <= timer_pkg::CNT_RST;
        end else if (ts_load_i) begin
            ts_count_o <= ts_value_i;
        end else if (ts_advance) begin
            ts_count_o <= ts_count_o + 1'b1; // [RL1]
        end
    end

    // ------------------------------------------------------------
    // compare register
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cmp_o <= timer_pkg::CNT_RST;
        end else if (cmp_write_i) begin
            cmp_o <= cmp_value_i;
        end
    end

    // ------------------------------------------------------------
    // timestamp match flag
    // ------------------------------------------------------------
    // a new match beats a same-cycle clear, so no match is lost;
    // the flag stays up until software pulses the clear input
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ts_irq_o <= 1'b0;
        end else if (ts_match) begin
            ts_irq_o <= 1'b1; // [RL8]
        end else if (ts_irq_clear_i) begin
            ts_irq_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // general-purpose timers: count down, reload at zero
    // ------------------------------------------------------------
    logic       gp0_run;
    logic       gp1_run;
    logic [1:0] gp_hit;
    // a channel moves only when enabled and its chosen enable fires
    assign gp0_run = gp_enable_i[0] && gp0_step; // [RL3]
    assign gp1_run = gp_enable_i[1] && gp1_step; // [RL3]
    // terminal count is zero; the reload lands in that same step, so the
    // period is the reload value plus one steps
    assign gp_hit  = {gp1_run && (gp1_count_o == '0),
                      gp0_run && (gp0_count_o == '0)}; // [RL10]

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            gp0_count_o <= timer_pkg::CNT_RST;
        end else if (gp_load_i[0] || gp_hit[0]) begin
            gp0_count_o <= gp0_reload_i; // [RL10]
        end else if (gp0_run) begin
            gp0_count_o <= gp0_count_o - 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            gp1_count_o <= timer_pkg::CNT_RST;
        end else if (gp_load_i[1] || gp_hit[1]) begin
            gp1_count_o <= gp1_reload_i; // [RL10]
        end else if (gp1_run) begin
            gp1_count_o <= gp1_count_o - 1'b1;
        end
    end

    // ------------------------------------------------------------
    // general-purpose terminal count flags
    // ------------------------------------------------------------
    // set wins over clear: a hit in the clear cycle stays visible,
    // software clears a bit by pulsing its clear input
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            gp_irq_o <= 2'h0;
        end else begin
            gp_irq_o <= gp_hit | (gp_irq_o & ~gp_irq_clear_i); // [RL10]
        end
    end
endmodule : quad_timer_with_prescaler

// file: quad_timer_properties.sv
// checker: port timing of the quad timer
`timescale 1ns/1ps
module quad_timer_properties (
    // clock and reset
    input wire logic        clock_i,
    input wire logic        arst_n_i,
    // controls
    input wire logic [15:0] pre_divide_m1_i,
    input wire logic        pre_src_alt_i,
    input wire logic        ts_use_pre_i,
    input wire logic        gp0_use_pre_i,
    input wire logic        wdog_enable_i,
    input wire logic        wdog_reload_i,
    input wire logic [31:0] wdog_value_i,
    input wire logic        ts_enable_i,
    input wire logic        ts_load_i,
    input wire logic [1:0]  gp_enable_i,
    input wire logic [1:0]  gp_load_i,
    input wire logic [31:0] gp0_reload_i,
    // status
    input wire logic [31:0] wdog_count_o,
    input wire logic        wdog_expired_o,
    input wire logic [31:0] ts_count_o,
    input wire logic [31:0] cmp_o,
    input wire logic [31:0] gp0_count_o,
    input wire logic [1:0]  gp_irq_o,
    input wire logic        ts_irq_o,
    input wire logic        pre_enable_o
);
    // ----------
    // properties
    // ----------
    wire wd_run = wdog_enable_i && !wdog_reload_i;
    wire ts_run = ts_enable_i && !ts_load_i;
    wire gp_run = gp_enable_i[0] && !gp_load_i[0] && !gp0_use_pre_i;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_div2;
        !pre_enable_o ##1 pre_enable_o;
    endsequence
    property p_wd_step;
        wd_run && wdog_count_o != 32'h0 |=> wdog_count_o == $past(wdog_count_o) - 32'h1;
    endproperty
    a_wd_step: assert property (p_wd_step)
        else $error("wdog step");
    property p_wd_exp;
        wd_run && wdog_count_o == 32'h0 |=> wdog_expired_o && wdog_count_o == 32'h0;
    endproperty
    a_wd_exp: assert property (p_wd_exp)
        else $error("wdog expiry");
    property p_wd_load;
        wdog_reload_i |=> !wdog_expired_o && wdog_count_o == $past(wdog_value_i);
    endproperty
    a_wd_load: assert property (p_wd_load)
        else $error("wdog reload");
    property p_ts_free;
        ts_run && !ts_use_pre_i |=> ts_count_o == $past(ts_count_o) + 32'h1;
    endproperty
    a_ts_free: assert property (p_ts_free)
        else $error("ts step");
    property p_ts_pre;
        ts_run && ts_use_pre_i |=> ts_count_o == $past(ts_count_o) + 32'(pre_enable_o);
    endproperty
    a_ts_pre: assert property (p_ts_pre)
        else $error("ts prescaled step");
    property p_ts_irq;
        ts_run && !ts_use_pre_i && ts_count_o == cmp_o |-> ##1 ts_irq_o;
    endproperty
    a_ts_irq: assert property (p_ts_irq)
        else $error("ts match");
    property p_gp_wrap;
        gp_run && gp0_count_o == 32'h0 |=> gp_irq_o[0] && gp0_count_o == $past(gp0_reload_i);
    endproperty
    a_gp_wrap: assert property (p_gp_wrap)
        else $error("gp wrap");
    // the step is compared with the enable port, which trails the internal enable that moved the count by one cycle
    property p_gp_pre;
        gp_enable_i[0] && !gp_load_i[0] && gp0_use_pre_i && gp0_count_o != 32'h0 |=>
            gp0_count_o == $past(gp0_count_o) - 32'(pre_enable_o);
    endproperty
    a_gp_pre: assert property (p_gp_pre)
        else $error("gp prescaled step");
    // ratio two on the bus clock: every second cycle
    // a source or ratio change leaves the count as it was, so only a settled setting
    property p_pre_div2;
        pre_enable_o && !pre_src_alt_i && pre_divide_m1_i == 16'h0001 &&
            $stable(pre_src_alt_i) && $stable(pre_divide_m1_i) |=> s_div2;
    endproperty
    a_pre_div2: assert property (p_pre_div2)
        else $error("prescaler gap");
endmodule : quad_timer_properties

// file: testbench.sv
// testbench: scoreboarded runs of the quad timer
`timescale 1ns/1ps
module testbench;
    logic        clock_i = 1'b0, arst_n_i = 1'b0, pre_src_alt_i, alt_tick_i, ts_use_pre_i;
    logic        gp0_use_pre_i, gp1_use_pre_i, wdog_enable_i, wdog_reload_i, ts_enable_i;
    logic        ts_load_i, cmp_write_i, ts_irq_clear_i, wdog_expired_o, ts_irq_o, pre_enable_o;
    logic [15:0] pre_divide_m1_i;
    logic [1:0]  gp_enable_i, gp_load_i, gp_irq_clear_i, gp_irq_o;
    logic [31:0] wdog_value_i, ts_value_i, cmp_value_i, gp0_reload_i, gp1_reload_i, v, w;
    logic [31:0] wdog_count_o, ts_count_o, cmp_o, gp0_count_o, gp1_count_o;
    logic [3:0]  prev_r = 4'h0, r;
    logic [35:0] notes[$];
    int          failures, compares, tk, k, n, e;
    quad_timer_with_prescaler dut_u (
        .clock_i         (clock_i),
        .arst_n_i        (arst_n_i),
        .pre_divide_m1_i (pre_divide_m1_i),
        .pre_src_alt_i   (pre_src_alt_i),
        .alt_tick_i      (alt_tick_i),
        .ts_use_pre_i    (ts_use_pre_i),
        .gp0_use_pre_i   (gp0_use_pre_i),
        .gp1_use_pre_i   (gp1_use_pre_i),
        .wdog_enable_i   (wdog_enable_i),
        .wdog_reload_i   (wdog_reload_i),
        .wdog_value_i    (wdog_value_i),
        .ts_enable_i     (ts_enable_i),
        .ts_load_i       (ts_load_i),
        .ts_value_i      (ts_value_i),
        .cmp_write_i     (cmp_write_i),
        .cmp_value_i     (cmp_value_i),
        .ts_irq_clear_i  (ts_irq_clear_i),
        .gp_enable_i     (gp_enable_i),
        .gp_load_i       (gp_load_i),
        .gp0_reload_i    (gp0_reload_i),
        .gp1_reload_i    (gp1_reload_i),
        .gp_irq_clear_i  (gp_irq_clear_i),
        .wdog_count_o    (wdog_count_o),
        .wdog_expired_o  (wdog_expired_o),
        .ts_count_o      (ts_count_o),
        .cmp_o           (cmp_o),
        .ts_irq_o        (ts_irq_o),
        .gp0_count_o     (gp0_count_o),
        .gp1_count_o     (gp1_count_o),
        .gp_irq_o        (gp_irq_o),
        .pre_enable_o    (pre_enable_o)
    );
    always #2.5 clock_i = ~clock_i;
    // ----------
    // drivers and monitor
    // ----------
    always @(posedge clock_i) begin
        #1 tk = tk + 1;
        alt_tick_i = (tk % 4) == 0; // 50 MHz tick: one clock in four
    end
    // flags are sticky, so only a rising flag is a new result;
    // looked at on the falling edge, where the outputs have settled
    always @(negedge clock_i) begin
        r = {gp_irq_o, ts_irq_o, wdog_expired_o} & ~prev_r;
        prev_r = {gp_irq_o, ts_irq_o, wdog_expired_o};
        v = r[0] ? wdog_count_o : r[1] ? ts_count_o : r[2] ? gp0_count_o : gp1_count_o;
        if (r != 4'h0)
            chk("event", notes.size() ? notes.pop_front() : 36'h0, {r, v});
    end
    task automatic chk(string nm, logic [35:0] x, logic [35:0] g);
        compares++;
        if (g !== x) begin
            failures++;
            $display("[FAIL] %s exp %h got %h", nm, x, g);
        end
    endtask : chk
    task automatic tick(int c);
        repeat (c) @(posedge clock_i);
        #1;
    endtask : tick
    task automatic drain();
        for (int i = 0; i < 100 && notes.size() != 0; i++) tick(1);
        if (notes.size() != 0) begin
            failures++;
            complete_run();
        end
    endtask : drain
    task automatic gap(output int c);
        c = 0;
        do begin tick(1); c++; end while (pre_enable_o !== 1'b1 && c < 300);
        if (pre_enable_o !== 1'b1) begin
            failures++;
            complete_run();
        end
    endtask : gap
    task automatic complete_run();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : complete_run
    initial begin
        {pre_divide_m1_i, pre_src_alt_i, ts_use_pre_i, gp0_use_pre_i, gp1_use_pre_i,
         wdog_enable_i, wdog_reload_i, ts_enable_i, ts_load_i, cmp_write_i, ts_irq_clear_i,
         gp_enable_i, gp_load_i, gp_irq_clear_i, wdog_value_i, ts_value_i, cmp_value_i,
         gp0_reload_i, gp1_reload_i} = '0;
        void'($urandom(20));
        tick(20);
        arst_n_i = 1'b1;
        chk("wdog reset", 36'hFFFFFFFF, 36'(wdog_count_o));
        w = ts_count_o | gp0_count_o | gp1_count_o | cmp_o;
        chk("reset", 36'h0, {gp_irq_o, ts_irq_o, wdog_expired_o, w});
        chk("enable reset", 36'h0, 36'(pre_enable_o));
        $display("reset test done");
        {wdog_value_i, wdog_reload_i} = {32'($urandom_range(9, 2)), 1'b1};
        tick(1);
        {wdog_reload_i, wdog_enable_i} = 2'b01;
        notes.push_back({4'h1, 32'h0});
        drain();
        {wdog_value_i, wdog_reload_i} = {32'hFFFFFFFF, 1'b1};
        tick(1);
        wdog_reload_i = 1'b0;
        chk("expiry", 36'h0, 36'(wdog_expired_o));
        $display("watchdog test done");
        e = $urandom_range(10, 3);
        {cmp_value_i, cmp_write_i, ts_load_i} = {32'(e), 2'b11};
        tick(1);
        {cmp_write_i, ts_load_i, ts_enable_i} = 3'b001;
        notes.push_back({4'h2, 32'(e + 1)});
        drain();
        chk("compare", 36'(e), 36'(cmp_o));
        ts_irq_clear_i = 1'b1;
        tick(1);
        ts_irq_clear_i = 1'b0;
        chk("ts irq", 36'h0, 36'(ts_irq_o));
        $display("timestamp test done");
        {gp0_reload_i, gp1_reload_i, gp_load_i} = {32'(e), 32'(e + 3), 2'b11};
        tick(1);
        {gp_load_i, gp_enable_i} = 4'b0011;
        notes.push_back({4'h4, 32'(e)});
        notes.push_back({4'h8, 32'(e + 3)});
        drain();
        {gp_enable_i, gp_irq_clear_i} = 4'b0011;
        tick(1);
        gp_irq_clear_i = 2'b00;
        chk("gp irq", 36'h0, 36'(gp_irq_o));
        $display("general timer test done");
        ts_use_pre_i = 1'b1;
        for (k = 0; k < 3; k++) begin
            pre_divide_m1_i = k == 0 ? 16'($urandom_range(6, 2)) : 16'h0001;
            pre_src_alt_i = k == 1;
            repeat (3) gap(n);
            e = (pre_divide_m1_i + 1) * (k == 1 ? 4 : 1);
            chk("enable gap", 36'(e), 36'(n));
        end
        $display("prescaler test done");
        e = $urandom_range(8, 2);
        {gp0_reload_i, gp1_reload_i, gp_load_i} = {32'(e), 32'(e + 5), 2'b11};
        {gp0_use_pre_i, gp1_use_pre_i} = 2'b11;
        tick(1);
        {gp_load_i, gp_enable_i} = 4'b0011;
        notes.push_back({4'h4, 32'(e)});
        notes.push_back({4'h8, 32'(e + 5)});
        drain();
        {gp_enable_i, gp_irq_clear_i} = 4'b0011;
        tick(1);
        gp_irq_clear_i = 2'b00;
        chk("gp prescaled irq", 36'h0, 36'(gp_irq_o));
        $display("prescaled general timer test done");
        complete_run();
    end
endmodule : testbench
bind quad_timer_with_prescaler quad_timer_properties chk_u (
    .clock_i         (clock_i),
    .arst_n_i        (arst_n_i),
    .pre_divide_m1_i (pre_divide_m1_i),
    .pre_src_alt_i   (pre_src_alt_i),
    .ts_use_pre_i    (ts_use_pre_i),
    .gp0_use_pre_i   (gp0_use_pre_i),
    .wdog_enable_i   (wdog_enable_i),
    .wdog_reload_i   (wdog_reload_i),
    .wdog_value_i    (wdog_value_i),
    .ts_enable_i     (ts_enable_i),
    .ts_load_i       (ts_load_i),
    .gp_enable_i     (gp_enable_i),
    .gp_load_i       (gp_load_i),
    .gp0_reload_i    (gp0_reload_i),
    .wdog_count_o    (wdog_count_o),
    .wdog_expired_o  (wdog_expired_o),
    .ts_count_o      (ts_count_o),
    .cmp_o           (cmp_o),
    .gp0_count_o     (gp0_count_o),
    .gp_irq_o        (gp_irq_o),
    .ts_irq_o        (ts_irq_o),
    .pre_enable_o    (pre_enable_o)
);
